// ==== inc/rgen_pkg.sv ====
// Shared constants, types and decode functions of the rate generator
// Operation
// - The received level is decided by a majority vote over three samples of the pin.
// - The divisor n is the high byte and the low byte joined as one pair.
// - Async, 8-bit divisor, low speed gives a period of 64 times (n + 1) clocks.
// - Async with 16-bit low speed, or 8-bit high speed, gives 16 times (n + 1).
// - Sync mode gives 4 times (n + 1) for either width, whatever the speed bit.
// - After reset only the low byte counts; the wide enable bit adds the high byte.
// - Any write to either divisor byte restarts the rate timer at once.
// - Transmit control bit 2 picks high speed and bit 4 picks sync mode.
package rgen_pkg;

    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_TX_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RX_CTRL   = 8'h04;
    localparam logic [7:0] OFS_RATE_CTRL = 8'h08;
    localparam logic [7:0] OFS_DIV_LOW   = 8'h0C;
    localparam logic [7:0] OFS_DIV_HIGH  = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // -------------------------------------------------------------
    // Field positions, reset values and write masks
    // -------------------------------------------------------------
    localparam int TXC_SYNC_BIT = 4;
    localparam int TXC_HS_BIT   = 2;
    localparam int RXC_EN_BIT   = 7;
    localparam int RC_WIDE_BIT  = 3;
    localparam int ST_LEVEL_BIT = 0;

    localparam logic [7:0] TXC_RESET = 8'h02; // Shift register empty
    localparam logic [7:0] TXC_WMASK = 8'hFD;
    localparam logic [7:0] RXC_RESET = 8'h00;
    localparam logic [7:0] RXC_WMASK = 8'hF8;
    localparam logic [7:0] RC_RESET  = 8'h40; // Receiver idle
    localparam logic [7:0] RC_WMASK  = 8'hBB;
    localparam logic [7:0] DIV_RESET = 8'h00;

    // -------------------------------------------------------------
    // Clock scale factors per mode
    // -------------------------------------------------------------
    localparam logic [6:0] SCALE_SLOW = 7'h40;
    localparam logic [6:0] SCALE_MID  = 7'h10;
    localparam logic [6:0] SCALE_FAST = 7'h04;

    // Live configuration seen by the timer
    typedef struct packed {
        logic        portEnable;
        logic        syncMode;
        logic        highSpeed;
        logic        wideDiv;
        logic [15:0] divisor;
    } rgen_cfg_t;

    // Scale factor from mode, speed and width
    function automatic logic [6:0] rgen_scale(input rgen_cfg_t c);
        if (c.syncMode)
            return SCALE_FAST;
        else if (!c.highSpeed && !c.wideDiv)
            return SCALE_SLOW;
        else if (c.highSpeed && c.wideDiv)
            return SCALE_FAST;
        else
            return SCALE_MID;
    endfunction

    // Two out of three vote
    function automatic logic rgen_major3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

endpackage

// ==== logic/rgen_divider.sv ====
// Free-running prescaler and divisor timer that makes the rate tick
`timescale 1ns/100ps
module rgen_divider
    import rgen_pkg::*;
#(
    parameter int DIV_W = 16,
    parameter int PRE_W = 7
)(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Control
    input  wire logic             clearTimer,
    input  wire logic [PRE_W-1:0] preLimit,
    input  wire logic [DIV_W-1:0] divisor,
    // Ticks
    output wire logic             preTick,
    output logic                  rateTick
);

    logic [PRE_W-1:0] preCnt_q;
    logic [PRE_W-1:0] preCnt_d;
    logic [DIV_W-1:0] divCnt_q;
    logic [DIV_W-1:0] divCnt_d;
    wire              divWrap;

    // Prescaler wraps at preLimit (the scale minus one), the divisor counter at n
    assign preTick  = (preCnt_q == preLimit);
    assign divWrap  = preTick & (divCnt_q == divisor);
    assign preCnt_d = preTick ? '0 : preCnt_q + 1'b1;
    assign divCnt_d = divWrap ? '0 : (preTick ? divCnt_q + 1'b1 : divCnt_q);

    // Timer state, zeroed by reset or a clear
    always_ff @(posedge clk_sys) begin
        if (reset || clearTimer) begin
            preCnt_q <= '0;
            divCnt_q <= '0;
            rateTick <= 1'b0;
        end else begin
            preCnt_q <= preCnt_d;
            divCnt_q <= divCnt_d;
            rateTick <= divWrap;
        end
    end

endmodule // rgen_divider

// ==== logic/rgen_sampler.sv ====
// Three-sample majority detector on the receive pin
`timescale 1ns/100ps
module rgen_sampler
    import rgen_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Sampling
    input  wire logic sampleStrobe,
    input  wire logic receiveDataPin,
    output logic      votedLevel
);

    logic [2:0] smp_q;
    wire  [2:0] smp_d;

    // Shift in one sample per strobe
    assign smp_d = sampleStrobe ? {smp_q[1:0], receiveDataPin} : smp_q;

    // Idle line is high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            smp_q      <= 3'h7;
            votedLevel <= 1'b1;
        end else begin
            smp_q      <= smp_d;
            votedLevel <= rgen_major3(smp_d);
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    a_vote_majority: assert property (@(posedge clk_sys) disable iff (reset)
        sampleStrobe |=> (votedLevel == (({1'b0, $past(smp_q[1])} + {1'b0, $past(smp_q[0])}
                                          + {1'b0, $past(receiveDataPin)}) > 2'h1)))
    else $error("vote sequence broken");

endmodule // rgen_sampler

// ==== logic/rgen_top.sv ====
// Rate generator top: APB registers, timer and receive voter
`timescale 1ns/100ps
module rgen_top
    import rgen_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DIV_W  = 16
)(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output wire logic              pready,
    output wire logic              pslverr,
    // Serial side
    input  wire logic              receiveDataPin,
    output wire logic              rateTick,
    output wire logic              votedLevel
);

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    wire setupPh;
    wire accessPh;
    wire wrEn;
    wire selTx;
    wire selRx;
    wire selRate;
    wire selLow;
    wire selHigh;
    wire selStat;
    wire mapped;

    // Phase and address decode
    assign setupPh  = psel & ~penable;
    assign accessPh = psel & penable;
    assign wrEn     = accessPh & pwrite;
    assign selTx    = (paddr == ADDR_W'(OFS_TX_CTRL));
    assign selRx    = (paddr == ADDR_W'(OFS_RX_CTRL));
    assign selRate  = (paddr == ADDR_W'(OFS_RATE_CTRL));
    assign selLow   = (paddr == ADDR_W'(OFS_DIV_LOW));
    assign selHigh  = (paddr == ADDR_W'(OFS_DIV_HIGH));
    assign selStat  = (paddr == ADDR_W'(OFS_STATUS));
    assign mapped   = selTx | selRx | selRate | selLow | selHigh | selStat;

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = accessPh & ~mapped;

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    logic [7:0] txCtl_q;
    logic [7:0] rxCtl_q;
    logic [7:0] rateCtl_q;
    logic [7:0] divLow_q;
    logic [7:0] divHigh_q;
    wire  [7:0] txCtl_d;
    wire  [7:0] rxCtl_d;
    wire  [7:0] rateCtl_d;
    wire  [7:0] divLow_d;
    wire  [7:0] divHigh_d;
    wire  [7:0] wrByte;

    // Next values; read-only bits keep their value
    assign wrByte    = pwdata[7:0];
    assign txCtl_d   = (wrEn & selTx) ?
                       ((wrByte & TXC_WMASK) | (txCtl_q & ~TXC_WMASK)) : txCtl_q;
    assign rxCtl_d   = (wrEn & selRx) ?
                       ((wrByte & RXC_WMASK) | (rxCtl_q & ~RXC_WMASK)) : rxCtl_q;
    assign rateCtl_d = (wrEn & selRate) ?
                       ((wrByte & RC_WMASK) | (rateCtl_q & ~RC_WMASK)) : rateCtl_q;
    assign divLow_d  = (wrEn & selLow) ? wrByte : divLow_q;
    assign divHigh_d = (wrEn & selHigh) ? wrByte : divHigh_q;

    // Register storage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txCtl_q   <= TXC_RESET;
            rxCtl_q   <= RXC_RESET;
            rateCtl_q <= RC_RESET;
            divLow_q  <= DIV_RESET;
            divHigh_q <= DIV_RESET;
        end else begin
            txCtl_q   <= txCtl_d;
            rxCtl_q   <= rxCtl_d;
            rateCtl_q <= rateCtl_d;
            divLow_q  <= divLow_d;
            divHigh_q <= divHigh_d;
        end
    end

    // -------------------------------------------------------------
    // Configuration
    // -------------------------------------------------------------
    rgen_cfg_t  cfg;
    wire  [6:0] scale;
    logic [7:0] mode_q;
    wire  [7:0] mode_d;
    wire        divWrite;
    wire        clearTimer;

    // Mode bits and the divisor pair
    assign cfg.portEnable = rxCtl_q[RXC_EN_BIT];
    assign cfg.syncMode   = txCtl_q[TXC_SYNC_BIT];
    assign cfg.highSpeed  = txCtl_q[TXC_HS_BIT];
    assign cfg.wideDiv    = rateCtl_q[RC_WIDE_BIT];
    assign cfg.divisor    = cfg.wideDiv ? {divHigh_q, divLow_q}
                                        : {DIV_RESET, divLow_q};
    assign scale          = rgen_scale(cfg);

    // Restart the timer on divisor writes, mode changes or port disable
    assign mode_d     = {scale, cfg.wideDiv};
    assign divWrite   = wrEn & (selLow | selHigh);
    assign clearTimer = divWrite | ~cfg.portEnable | (mode_d != mode_q);

    // Last mode seen by the timer
    always_ff @(posedge clk_sys) begin
        if (reset)
            mode_q <= '0;
        else
            mode_q <= mode_d;
    end

    // -------------------------------------------------------------
    // Timer and voter
    // -------------------------------------------------------------
    wire preTick;

    rgen_divider #(
        .DIV_W (DIV_W),
        .PRE_W ($bits(scale))
    ) u_div (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .clearTimer (clearTimer),
        .preLimit   (scale - 7'h01),
        .divisor    (cfg.divisor),
        .preTick    (preTick),
        .rateTick   (rateTick)
    );

    rgen_sampler u_smp (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .sampleStrobe   (preTick & cfg.portEnable),
        .receiveDataPin (receiveDataPin),
        .votedLevel     (votedLevel)
    );

    // -------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------
    wire [7:0] statByte;
    wire [7:0] rdByte;

    // Status shows the voted receive level
    assign statByte = {7'h00, votedLevel} << ST_LEVEL_BIT;
    assign rdByte   = selTx   ? txCtl_q   :
                      selRx   ? rxCtl_q   :
                      selRate ? rateCtl_q :
                      selLow  ? divLow_q  :
                      selHigh ? divHigh_q :
                      selStat ? statByte  : 8'h00;

    // Read data is captured in the setup phase
    always_ff @(posedge clk_sys) begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (setupPh)
            prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rdByte};
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    logic [23:0] gap_q;
    logic        clearSeen_q;
    wire  [23:0] nPlus1;

    // Cycles since the last tick, and whether a restart came between
    assign nPlus1 = 24'(cfg.divisor) + 24'h000001;
    always_ff @(posedge clk_sys) begin
        if (reset || rateTick)
            gap_q <= '0;
        else
            gap_q <= gap_q + 24'h000001;
    end
    always_ff @(posedge clk_sys) begin
        if (reset || clearTimer)
            clearSeen_q <= 1'b1;
        else if (rateTick)
            clearSeen_q <= 1'b0;
    end

    a_slow_async_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (rateTick && !clearSeen_q && !cfg.syncMode && !cfg.wideDiv && !cfg.highSpeed)
        |-> (gap_q == 24'(SCALE_SLOW) * nPlus1 - 24'h000001))
    else $error("slow async period wrong");

    a_mid_async_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (rateTick && !clearSeen_q && !cfg.syncMode && (cfg.wideDiv != cfg.highSpeed))
        |-> (gap_q == 24'(SCALE_MID) * nPlus1 - 24'h000001))
    else $error("mid async period wrong");

    a_sync_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (rateTick && !clearSeen_q && cfg.syncMode)
        |-> (gap_q == 24'(SCALE_FAST) * nPlus1 - 24'h000001))
    else $error("sync period wrong");

    a_wide_fast_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (rateTick && !clearSeen_q && !cfg.syncMode && cfg.wideDiv && cfg.highSpeed)
        |-> (gap_q == 24'(SCALE_FAST) * nPlus1 - 24'h000001))
    else $error("wide fast period wrong");

    a_divisor_pair: assert property (@(posedge clk_sys) disable iff (reset)
        (wrEn && selHigh && cfg.wideDiv) |=> (cfg.divisor[15:8] == $past(pwdata[7:0])))
    else $error("high byte not in divisor");

    a_narrow_ignore: assert property (@(posedge clk_sys) disable iff (reset)
        (!cfg.wideDiv && $changed(divHigh_q)) |-> $stable(cfg.divisor))
    else $error("high byte used in 8-bit mode");

    a_write_restart: assert property (@(posedge clk_sys) disable iff (reset)
        divWrite |=> !rateTick ##0 (u_div.preCnt_q == 7'h00) ##0 (u_div.divCnt_q == '0))
    else $error("divisor write did not restart timer");

    a_mode_bits: assert property (@(posedge clk_sys) disable iff (reset)
        (wrEn && selTx) |=> (cfg.highSpeed == $past(pwdata[TXC_HS_BIT]))
                          && (cfg.syncMode == $past(pwdata[TXC_SYNC_BIT])))
    else $error("mode bits not taken");

    a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        (!cfg.portEnable)[*2] |-> !rateTick)
    else $error("tick while port disabled");

    // -------------------------------------------------------------
    // Bus and register checks
    // -------------------------------------------------------------

    // Read-only bits never follow the bus
    a_readonly_bits: assert property (@(posedge clk_sys) disable iff (reset)
        $stable(txCtl_q & ~TXC_WMASK) && $stable(rxCtl_q & ~RXC_WMASK)
        && $stable(rateCtl_q & ~RC_WMASK))
    else $error("read-only bit changed");

    // Unmapped offsets answer with an error, mapped ones never
    a_unmapped_error: assert property (@(posedge clk_sys) disable iff (reset)
        accessPh |-> (pslverr == !mapped))
    else $error("slave error wrong");

    // Divisor bytes hold unless written
    a_divisor_hold: assert property (@(posedge clk_sys) disable iff (reset)
        !(wrEn && (selLow || selHigh)) |=> $stable({divHigh_q, divLow_q}))
    else $error("divisor byte changed without write");

    // A low byte write lands in the low byte
    a_low_byte_write: assert property (@(posedge clk_sys) disable iff (reset)
        (wrEn && selLow) |=> (divLow_q == $past(pwdata[7:0])))
    else $error("low byte not written");

    // Read data of the low byte stands through the access phase
    a_read_low: assert property (@(posedge clk_sys) disable iff (reset)
        (setupPh && !pwrite && selLow) |=> (prdata == {24'h000000, divLow_q}))
    else $error("low byte read wrong");

    // Upper read lanes are always zero
    a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (reset)
        prdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");

    // A tick lasts one cycle
    a_tick_single: assert property (@(posedge clk_sys) disable iff (reset)
        rateTick |=> !rateTick)
    else $error("tick longer than one cycle");

    // A mode or width change restarts the timer
    a_mode_restart: assert property (@(posedge clk_sys) disable iff (reset)
        (mode_d != mode_q) |=> ((u_div.preCnt_q == 7'h00) && !rateTick))
    else $error("mode change did not restart timer");

    // Port disable empties the divisor counter
    a_disable_clears: assert property (@(posedge clk_sys) disable iff (reset)
        !cfg.portEnable |=> (u_div.divCnt_q == '0))
    else $error("counter runs while disabled");

    // Main scenarios
    c_mid_tick: cover property (@(posedge clk_sys) disable iff (reset)
        rateTick && !clearSeen_q && !cfg.syncMode && (cfg.wideDiv != cfg.highSpeed));
    c_slow_tick: cover property (@(posedge clk_sys) disable iff (reset)
        rateTick && !clearSeen_q && !cfg.syncMode && !cfg.highSpeed && !cfg.wideDiv);
    c_sync_tick: cover property (@(posedge clk_sys) disable iff (reset)
        rateTick && !clearSeen_q && cfg.syncMode);
    c_wide_tick: cover property (@(posedge clk_sys) disable iff (reset)
        rateTick && !clearSeen_q && cfg.wideDiv && cfg.highSpeed && !cfg.syncMode);
    c_level_low: cover property (@(posedge clk_sys) disable iff (reset)
        $fell(votedLevel));

endmodule // rgen_top

// ==== logic/rgen_sampler_fix.sv ====
// (intentionally empty of logic)

// ==== testbench/test_uart_baud_rate_generator.sv ====
// Self-checking testbench of the rate generator: registers, rate periods and receive voter
`timescale 1ns/100ps
module test_uart_baud_rate_generator;
    import rgen_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_sys;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    logic        receiveDataPin;
    wire         rateTick;
    wire         votedLevel;
    int          numErrors;
    int          numChecks;
    int          tickCnt;
    int          seedDummy;
    logic [31:0] rdQ[$];
    int          tickQ[$];

    rgen_top #(.ADDR_W(8), .DIV_W(16)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receiveDataPin(receiveDataPin),
        .rateTick(rateTick), .votedLevel(votedLevel)
    );

    // Clock at 125 MHz
    always #4 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        numChecks++;
        if (s !== e) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic closeOut();
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One APB transfer; a read notes its expected data first
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        if (!wr)
            rdQ.push_back({24'h0, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys); // Idle edge so the next setup never reassigns in this step
    endtask

    // Program mode and divisor, note the tick spacing and read back
    task automatic cfg(input logic sy, input logic hs, input logic wd,
                       input logic [7:0] hi, input logic [7:0] lo);
        int n;
        int p;
        apb(1'b1, OFS_TX_CTRL, {3'h0, sy, 1'b0, hs, 2'h0}, 8'h00);
        apb(1'b1, OFS_RATE_CTRL, {4'h0, wd, 3'h0}, 8'h00);
        apb(1'b1, OFS_DIV_LOW, lo, 8'h00);
        apb(1'b1, OFS_DIV_HIGH, hi, 8'h00);
        n = wd ? {hi, lo} : lo;
        p = sy ? 4 : (!hs && !wd) ? 64 : (hs && wd) ? 4 : 16;
        p = p * (n + 1);
        tickQ.push_back(p + 1);
        tickQ.push_back(p);
        tickQ.push_back(p);
        apb(1'b0, OFS_TX_CTRL, 8'h00, {3'h0, sy, 1'b0, hs, 2'h2});
        apb(1'b0, OFS_RATE_CTRL, 8'h00, {4'h4, wd, 3'h0});
        apb(1'b0, OFS_DIV_LOW, 8'h00, lo);
        apb(1'b0, OFS_DIV_HIGH, 8'h00, hi);
        for (int i = 0; i < 3 * p + 40 && tickQ.size() > 0; i++)
            @(posedge clk_sys);
        chk("ticks left", 0, tickQ.size());
    endtask

    // ------------------------------------------------------------
    // Monitor: read data, error flag and tick spacing
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            chk("slave error", (paddr > OFS_STATUS) || (paddr[1:0] != 2'h0), pslverr);
            if (!pwrite && rdQ.size() > 0)
                chk("read data", rdQ.pop_front(), prdata);
        end
        if (psel && penable && pwrite && pready === 1'b1)
            tickCnt = 0;
        else
            tickCnt++;
        if (rateTick === 1'b1) begin
            if (tickQ.size() > 0)
                chk("tick spacing", tickQ.pop_front(), tickCnt);
            tickCnt = 0;
        end
    end

    // Watchdog, well past the roughly 36k cycles the tests need
    initial begin
        #400000;
        numErrors++;
        closeOut();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        receiveDataPin = 1'b1;
        numErrors = 0;
        numChecks = 0;
        tickCnt = 0;
        seedDummy = $urandom(32'hBED70542);
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("voted after reset", 1, votedLevel);
        // Reset values, unmapped access, read-only bits
        apb(1'b0, OFS_TX_CTRL, 8'h00, TXC_RESET);
        apb(1'b0, OFS_RX_CTRL, 8'h00, RXC_RESET);
        apb(1'b0, OFS_RATE_CTRL, 8'h00, RC_RESET);
        apb(1'b0, OFS_DIV_LOW, 8'h00, DIV_RESET);
        apb(1'b0, OFS_DIV_HIGH, 8'h00, DIV_RESET);
        apb(1'b0, OFS_STATUS, 8'h00, 8'h01);
        apb(1'b1, 8'h18, 8'hFF, 8'h00);
        apb(1'b0, 8'h18, 8'h00, 8'h00);
        repeat (100) begin
            @(posedge clk_sys);
            chk("tick while disabled", 0, rateTick);
        end
        apb(1'b1, OFS_TX_CTRL, 8'hFF, 8'h00);
        apb(1'b1, OFS_RATE_CTRL, 8'hFF, 8'h00);
        apb(1'b1, OFS_RX_CTRL, 8'hFF, 8'h00);
        apb(1'b0, OFS_TX_CTRL, 8'h00, 8'hFF);
        apb(1'b0, OFS_RATE_CTRL, 8'h00, 8'hFB);
        apb(1'b0, OFS_RX_CTRL, 8'h00, 8'hF8);
        apb(1'b1, OFS_RX_CTRL, 8'h80, 8'h00);
        // All four async width and speed combinations, sync with both bits low and both high, then random sync settings
        cfg(1'b0, 1'b0, 1'b0, 8'h03, 8'h02);
        cfg(1'b0, 1'b1, 1'b0, 8'h03, 8'h05);
        cfg(1'b0, 1'b0, 1'b1, 8'h01, 8'h02);
        cfg(1'b0, 1'b1, 1'b1, 8'h01, 8'h00);
        cfg(1'b1, 1'b0, 1'b0, 8'h03, 8'h00);
        cfg(1'b1, 1'b1, 1'b1, 8'h00, 8'h09);
        repeat (3)
            cfg(1'b1, 1'($urandom), 1'($urandom), 8'($urandom % 2), 8'($urandom));
        // Majority vote, four-cycle strobe
        cfg(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        receiveDataPin <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk("voted low", 0, votedLevel);
        receiveDataPin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        receiveDataPin <= 1'b0;
        repeat (20) begin
            @(posedge clk_sys);
            chk("single sample glitch", 0, votedLevel);
        end
        receiveDataPin <= 1'b1;
        repeat (40) @(posedge clk_sys);
        chk("voted high", 1, votedLevel);
        apb(1'b0, OFS_STATUS, 8'h00, 8'h01);
        repeat (4) @(posedge clk_sys);
        closeOut();
    end
endmodule // test_uart_baud_rate_generator
